// file: rtl/omm_pkg.sv
// Shared constants and types for the optical module management interface.
package omm_pkg;
    // Seven-bit bus addresses of the two memory maps.
    localparam logic [6:0] DEV_ADDR_ID   = 7'h50;
    localparam logic [6:0] DEV_ADDR_DIAG = 7'h51;
    localparam int         MAP_BYTES     = 256;

    // Monitored quantities, each a 16-bit word stored high byte first.
    localparam int Q_TEMP  = 0;
    localparam int Q_VCC   = 1;
    localparam int Q_BIAS  = 2;
    localparam int Q_TXPWR = 3;
    localparam int Q_RXPWR = 4;
    localparam int QTY     = 5;
    localparam int VAL_W   = 16;

    // Diagnostics map byte offsets.
    localparam logic [7:0] DG_VAL_END  = 8'h0A;
    localparam logic [7:0] DG_ALM_HIGH = 8'h0A;
    localparam logic [7:0] DG_ALM_LOW  = 8'h0B;
    localparam logic [7:0] DG_WRN_HIGH = 8'h0C;
    localparam logic [7:0] DG_WRN_LOW  = 8'h0D;
    localparam logic [7:0] DG_CTRL     = 8'h0E;

    // Control and status byte fields.
    localparam int         CTRL_EXT_CAL  = 0;
    localparam int         CTRL_TX_DIS   = 1;
    localparam int         CTRL_TX_FAULT = 2;
    localparam int         CTRL_LOS      = 3;
    localparam logic       EXT_CAL_RST   = 1'b0;

    // Transmitter disable deadline.
    localparam int CLK_PERIOD_PS   = 8000;
    localparam int TX_DIS_TIME_US  = 10;
    localparam int TX_DIS_MAX_CYC  = (TX_DIS_TIME_US * 1000000) / CLK_PERIOD_PS;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_DEV     = 4'h1,
        ST_DEV_ACK = 4'h3,
        ST_REG     = 4'h2,
        ST_REG_ACK = 4'h6,
        ST_WR      = 4'h7,
        ST_WR_ACK  = 4'h5,
        ST_RD      = 4'h4,
        ST_RD_ACK  = 4'hC
    } omm_link_state_e;
endpackage : omm_pkg

// file: rtl/omm_diag_ctrl.sv
// Diagnostics controller: calibration and alarm and warning comparison.
`timescale 1ns/100ps
module omm_diag_ctrl #(
    parameter logic [79:0] CAL_OFFSET = {5{16'h0000}},
    parameter logic [79:0] ALM_HIGH   = {5{16'hF000}},
    parameter logic [79:0] ALM_LOW    = {5{16'h0100}},
    parameter logic [79:0] WRN_HIGH   = {5{16'hE000}},
    parameter logic [79:0] WRN_LOW    = {5{16'h0200}}
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    // Mode and raw monitor words
    input  wire logic        i_ext_cal,
    input  wire logic [79:0] i_raw,
    // Reported words and flags
    output logic      [79:0] o_value,
    output logic      [4:0]  o_alm_high,
    output logic      [4:0]  o_alm_low,
    output logic      [4:0]  o_wrn_high,
    output logic      [4:0]  o_wrn_low,
    output logic             o_tx_fault
);
    localparam int W = omm_pkg::VAL_W;

    logic [79:0] val_d;
    logic [4:0]  ah_d;
    logic [4:0]  al_d;
    logic [4:0]  wh_d;
    logic [4:0]  wl_d;
    logic        fault_d;

    genvar g;
    generate
        for (g = 0; g < omm_pkg::QTY; g++)
        begin : g_qty
            // Internal calibration adds the factory offset; external mode reports raw counts.
            assign val_d[g*W +: W] = i_ext_cal ? i_raw[g*W +: W]
                                   : i_raw[g*W +: W] + CAL_OFFSET[g*W +: W];
            assign ah_d[g] = val_d[g*W +: W] > ALM_HIGH[g*W +: W];
            assign al_d[g] = val_d[g*W +: W] < ALM_LOW[g*W +: W];
            assign wh_d[g] = val_d[g*W +: W] > WRN_HIGH[g*W +: W];
            assign wl_d[g] = val_d[g*W +: W] < WRN_LOW[g*W +: W];
        end
    endgenerate

    assign fault_d = ah_d[omm_pkg::Q_BIAS] | ah_d[omm_pkg::Q_TXPWR];

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_value    <= '0;
            o_alm_high <= '0;
            o_alm_low  <= '0;
            o_wrn_high <= '0;
            o_wrn_low  <= '0;
            o_tx_fault <= 1'b0;
        end
        else
        begin
            o_value    <= val_d;
            o_alm_high <= ah_d;
            o_alm_low  <= al_d;
            o_wrn_high <= wh_d;
            o_wrn_low  <= wl_d;
            o_tx_fault <= fault_d;
        end
    end

    a_cal_internal: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_ext_cal |=> o_value[15:0] == 16'($past(i_raw[15:0]) + CAL_OFFSET[15:0]))
        else $error("internal calibration not applied");
    a_alarm_high: assert property (@(posedge i_clk) disable iff (i_srst)
        !$past(i_srst) && $past(val_d[47:32]) > ALM_HIGH[47:32]
        |-> o_alm_high[omm_pkg::Q_BIAS])
        else $error("high alarm flag missing");
    a_fault_cause: assert property (@(posedge i_clk) disable iff (i_srst)
        !$past(i_srst) |-> o_tx_fault == ($past(val_d[47:32]) > ALM_HIGH[47:32]
                                       || $past(val_d[63:48]) > ALM_HIGH[63:48]))
        else $error("transmitter fault does not follow bias or power alarm");
endmodule : omm_diag_ctrl

// file: rtl/omm_mgmt_top.sv
// Management side of the optical module: two-wire slave, status pins, diagnostics.
`timescale 1ns/100ps
module omm_mgmt_top (
    // System clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    // Two-wire link
    input  wire logic        i_scl_clk,
    input  wire logic        i_sda,
    output logic             o_sda,
    output logic             o_sda_oe_n,
    // Module pins
    input  wire logic        i_transmitter_disable_input,
    input  wire logic        i_rx_signal_detect,
    input  wire logic        i_id_wp,
    output logic             o_laser_en,
    output logic             o_signal_lost_flag,
    output logic             o_transmitter_fault_flag,
    output logic             o_present_n,
    output logic             o_ext_cal,
    output logic             o_link_busy,
    // Raw monitor words
    input  wire logic [15:0] i_temp_raw,
    input  wire logic [15:0] i_vcc_raw,
    input  wire logic [15:0] i_bias_raw,
    input  wire logic [15:0] i_txpwr_raw,
    input  wire logic [15:0] i_rxpwr_raw
);
    localparam int TXD_MAX = omm_pkg::TX_DIS_MAX_CYC;

    // System domain.
    logic [4:0]  meta_q;
    logic [4:0]  sync_q;
    logic [1:0]  prev_q;
    logic        busy_d;
    logic        stop_pend_q;
    logic        stop_pend_d;
    logic [79:0] snap_val_q;
    logic [79:0] snap_val_d;
    logic [39:0] snap_flg_q;
    logic [39:0] snap_flg_d;
    logic [79:0] dg_val;
    logic [4:0]  ah;
    logic [4:0]  al;
    logic [4:0]  wh;
    logic [4:0]  wl;
    logic        dg_fault;
    logic        start_s;
    logic        stop_s;
    // Link domain.
    logic        ext_cal_q;
    logic        ext_cal_d;
    logic        sda_r_q;
    logic        wp_meta_q;
    logic        wp_q;
    logic        lrst_meta_q;
    logic        lrst_q;
    logic [7:0]  id_mem [omm_pkg::MAP_BYTES];
    omm_pkg::omm_link_state_e st_q;
    omm_pkg::omm_link_state_e st_d;
    logic [2:0]  cnt_q;
    logic [2:0]  cnt_d;
    logic [6:0]  shift_q;
    logic [6:0]  shift_d;
    logic [7:0]  addr_q;
    logic [7:0]  addr_d;
    logic        map_q;
    logic        map_d;
    logic        rw_q;
    logic        rw_d;
    logic [7:0]  tx_q;
    logic [7:0]  tx_d;
    logic        oe_n_d;
    logic [7:0]  rx_byte;
    logic [7:0]  rd_byte;
    logic        dev_hit;
    logic        start_l;
    logic        wr_last;

    omm_diag_ctrl u_diag (
        .i_clk      (i_clk),
        .i_srst     (i_srst),
        .i_ext_cal  (o_ext_cal),
        .i_raw      ({i_rxpwr_raw, i_txpwr_raw, i_bias_raw, i_vcc_raw, i_temp_raw}),
        .o_value    (dg_val),
        .o_alm_high (ah),
        .o_alm_low  (al),
        .o_wrn_high (wh),
        .o_wrn_low  (wl),
        .o_tx_fault (dg_fault)
    );

    // Sync bits: 4 ext_cal, 3 disable, 2 signal detect, 1 clock, 0 data.
    assign start_s = sync_q[1] & prev_q[1] & prev_q[0] & ~sync_q[0];
    assign stop_s  = sync_q[1] & prev_q[1] & ~prev_q[0] & sync_q[0];

    always_comb
    begin
        busy_d      = start_s ? 1'b1 : (stop_s ? 1'b0 : o_link_busy);
        stop_pend_d = stop_pend_q;
        if (stop_s)
            stop_pend_d = 1'b1;
        else if (!sync_q[1])
            stop_pend_d = 1'b0;
        // The snapshot only moves between frames, so the link reads it quasi-statically.
        snap_val_d = o_link_busy ? snap_val_q : dg_val;
        snap_flg_d = snap_flg_q;
        if (!o_link_busy)
        begin
            snap_flg_d = {4'h0, o_signal_lost_flag, o_transmitter_fault_flag, ~o_laser_en,
                          o_ext_cal, 3'h0, wl, 3'h0, wh, 3'h0, al, 3'h0, ah};
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            // Safe pin levels, so the laser cannot blink on as reset is released.
            meta_q      <= 5'h0B;
            sync_q      <= 5'h0B;
            prev_q      <= 2'h3;
            o_link_busy <= 1'b0;
            stop_pend_q <= 1'b1;
            snap_val_q  <= '0;
            snap_flg_q  <= '0;
            o_sda       <= 1'b0;
            o_laser_en  <= 1'b0;
            o_signal_lost_flag       <= 1'b1;
            o_transmitter_fault_flag <= 1'b0;
            o_present_n <= 1'b0;
            o_ext_cal   <= omm_pkg::EXT_CAL_RST;
        end
        else
        begin
            meta_q      <= {ext_cal_q, i_transmitter_disable_input, i_rx_signal_detect,
                            i_scl_clk, i_sda};
            sync_q      <= meta_q;
            prev_q      <= sync_q[1:0];
            o_link_busy <= busy_d;
            stop_pend_q <= stop_pend_d;
            snap_val_q  <= snap_val_d;
            snap_flg_q  <= snap_flg_d;
            o_sda       <= 1'b0;
            o_laser_en  <= ~sync_q[3];
            o_signal_lost_flag       <= ~sync_q[2];
            o_transmitter_fault_flag <= dg_fault;
            o_present_n <= 1'b0;
            o_ext_cal   <= sync_q[4];
        end
    end

    // Link rising edge: bit capture, write-protect and reset synchronisers, storage.
    assign wr_last   = (st_q == omm_pkg::ST_WR) && (cnt_q == 3'h7);
    assign ext_cal_d = (wr_last && map_q && addr_q == omm_pkg::DG_CTRL) ? i_sda
                     : ext_cal_q;

    always_ff @(posedge i_scl_clk)
    begin
        sda_r_q     <= i_sda;
        wp_meta_q   <= i_id_wp;
        wp_q        <= wp_meta_q;
        lrst_meta_q <= i_srst;
        lrst_q      <= lrst_meta_q;
        ext_cal_q   <= lrst_q ? omm_pkg::EXT_CAL_RST : ext_cal_d;
        if (wr_last && !map_q && !wp_q)
            id_mem[addr_q] <= {shift_q, i_sda};
    end

    // Link falling edge: framing, addressing and data output.
    assign rx_byte = {shift_q, sda_r_q};
    assign dev_hit = (rx_byte[7:1] == omm_pkg::DEV_ADDR_ID)
                   || (rx_byte[7:1] == omm_pkg::DEV_ADDR_DIAG);
    // A start right after a stop has no rising edge between, so the system side flags it.
    assign start_l = (sda_r_q & ~i_sda) | stop_pend_q;

    always_comb
    begin
        rd_byte = 8'h00;
        if (!map_q)
            rd_byte = id_mem[addr_q];
        else if (addr_q < omm_pkg::DG_VAL_END)
            rd_byte = snap_val_q[{addr_q[3:1], ~addr_q[0], 3'h0} +: 8];
        else if (addr_q <= omm_pkg::DG_CTRL)
            rd_byte = snap_flg_q[{addr_q[2:0] - 3'h2, 3'h0} +: 8];
    end

    always_comb
    begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        shift_d = shift_q;
        addr_d  = addr_q;
        map_d   = map_q;
        rw_d    = rw_q;
        tx_d    = tx_q;
        oe_n_d  = 1'b1;
        case (st_q)
            omm_pkg::ST_IDLE:
                st_d = omm_pkg::ST_IDLE;
            omm_pkg::ST_DEV, omm_pkg::ST_REG, omm_pkg::ST_WR:
            begin
                shift_d = rx_byte[6:0];
                cnt_d   = cnt_q + 3'h1;
                if (cnt_q == 3'h7)
                begin
                    oe_n_d = 1'b0;
                    if (st_q == omm_pkg::ST_DEV)
                    begin
                        st_d   = dev_hit ? omm_pkg::ST_DEV_ACK : omm_pkg::ST_IDLE;
                        oe_n_d = ~dev_hit;
                        map_d  = rx_byte[1];
                        rw_d   = rx_byte[0];
                    end
                    else if (st_q == omm_pkg::ST_REG)
                    begin
                        st_d   = omm_pkg::ST_REG_ACK;
                        addr_d = rx_byte;
                    end
                    else
                    begin
                        st_d   = omm_pkg::ST_WR_ACK;
                        addr_d = addr_q + 8'h01;
                    end
                end
            end
            omm_pkg::ST_DEV_ACK:
            begin
                st_d   = rw_q ? omm_pkg::ST_RD : omm_pkg::ST_REG;
                tx_d   = rd_byte;
                oe_n_d = rw_q ? rd_byte[7] : 1'b1;
            end
            omm_pkg::ST_REG_ACK, omm_pkg::ST_WR_ACK:
                st_d = omm_pkg::ST_WR;
            omm_pkg::ST_RD:
            begin
                cnt_d = cnt_q + 3'h1;
                if (cnt_q == 3'h7)
                begin
                    st_d   = omm_pkg::ST_RD_ACK;
                    addr_d = addr_q + 8'h01;
                end
                else
                begin
                    tx_d   = {tx_q[6:0], 1'b0};
                    oe_n_d = tx_q[6];
                end
            end
            omm_pkg::ST_RD_ACK:
            begin
                st_d   = sda_r_q ? omm_pkg::ST_IDLE : omm_pkg::ST_RD;
                tx_d   = rd_byte;
                oe_n_d = sda_r_q | rd_byte[7];
            end
            default:
                st_d = omm_pkg::ST_IDLE;
        endcase
        if (start_l)
        begin
            st_d   = omm_pkg::ST_DEV;
            cnt_d  = 3'h0;
            oe_n_d = 1'b1;
        end
    end

    always_ff @(negedge i_scl_clk)
    begin
        if (lrst_q)
        begin
            st_q       <= omm_pkg::ST_IDLE;
            cnt_q      <= 3'h0;
            shift_q    <= 7'h00;
            addr_q     <= 8'h00;
            map_q      <= 1'b0;
            rw_q       <= 1'b0;
            tx_q       <= 8'h00;
            o_sda_oe_n <= 1'b1;
        end
        else
        begin
            st_q       <= st_d;
            cnt_q      <= cnt_d;
            shift_q    <= shift_d;
            addr_q     <= addr_d;
            map_q      <= map_d;
            rw_q       <= rw_d;
            tx_q       <= tx_d;
            o_sda_oe_n <= oe_n_d;
        end
    end

    // Helper: cycles the laser stays on while disable is requested.
    logic [11:0] txd_wait_q;
    always_ff @(posedge i_clk)
    begin
        if (i_srst || !sync_q[3] || !o_laser_en)
            txd_wait_q <= 12'h000;
        else
            txd_wait_q <= txd_wait_q + 12'h001;
    end

    sequence s_dev_byte_done;
        st_q == omm_pkg::ST_DEV && cnt_q == 3'h7 && !start_l;
    endsequence
    sequence s_transmitter_disable_input_held;
        i_transmitter_disable_input [*3];
    endsequence

    a_laser_deadline: assert property (@(posedge i_clk) disable iff (i_srst)
        int'(txd_wait_q) <= TXD_MAX)
        else $error("laser still on past disable deadline");
    a_laser_off: assert property (@(posedge i_clk) disable iff (i_srst)
        s_transmitter_disable_input_held |=> !o_laser_en)
        else $error("laser on while disable held");
    a_los_follow: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_rx_signal_detect [*3] |=> o_signal_lost_flag)
        else $error("loss of signal not reported");
    a_frame_busy: assert property (@(posedge i_clk) disable iff (i_srst)
        start_s |=> o_link_busy ##0 stop_pend_q == $past(stop_pend_q))
        else $error("start marker not detected");
    a_own_ack: assert property (@(negedge i_scl_clk) disable iff (lrst_q)
        s_dev_byte_done ##0 dev_hit |=> !o_sda_oe_n && st_q == omm_pkg::ST_DEV_ACK)
        else $error("own address not acknowledged");
    a_foreign_nack: assert property (@(negedge i_scl_clk) disable iff (lrst_q)
        s_dev_byte_done ##0 !dev_hit |=> o_sda_oe_n && st_q == omm_pkg::ST_IDLE)
        else $error("foreign address acknowledged");
    a_read_bit: assert property (@(negedge i_scl_clk) disable iff (lrst_q)
        st_q == omm_pkg::ST_RD |-> o_sda_oe_n == tx_q[7])
        else $error("read bit not on data line");
    a_host_slot: assert property (@(negedge i_scl_clk) disable iff (lrst_q)
        st_q == omm_pkg::ST_RD_ACK |-> o_sda_oe_n)
        else $error("data line held in host acknowledge slot");
    a_addr_step: assert property (@(negedge i_scl_clk) disable iff (lrst_q)
        st_q == omm_pkg::ST_RD && cnt_q == 3'h7 && !start_l |=> addr_q == $past(addr_q) + 8'h01)
        else $error("address did not advance after read");
    a_ctrl_write: assert property (@(posedge i_scl_clk) disable iff (lrst_q)
        wr_last && map_q && addr_q == omm_pkg::DG_CTRL |=> ext_cal_q == $past(i_sda))
        else $error("control byte write not stored");
endmodule : omm_mgmt_top

// file: test/omm_host_model.sv
// Behavioural two-wire host that makes the serial clock and pulls the data line.
`timescale 1ns/100ps
module omm_host_model (
    // Resolved data line
    input  wire logic i_sda,
    // Host side of the link
    output logic      o_scl,
    output logic      o_sda_low
);
    logic tick;

    // Each data-bit clock half spans eight 15 ns ticks, well above four system cycles; idle pulses use one tick per half.
    initial
    begin
        tick      = 1'b0;
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
        forever #7.5 tick = ~tick;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge tick);
    endtask : hold

    // Data only changes while the clock is low and is sampled mid-high.
    task automatic clk_bit(input logic low, output logic seen);
        o_sda_low = low;
        hold(4);
        o_scl = 1'b1;
        hold(4);
        seen = i_sda;
        hold(4);
        o_scl = 1'b0;
        hold(4);
    endtask : clk_bit

    // Clock pulses with the data line high, so no start is seen during reset.
    task automatic idle_pulses(input int n);
        o_sda_low = 1'b0;
        repeat (n)
        begin
            o_scl = 1'b0;
            hold(1);
            o_scl = 1'b1;
            hold(1);
        end
    endtask : idle_pulses

    task automatic bus_start();
        o_sda_low = 1'b0;
        hold(4);
        o_scl = 1'b1;
        hold(8);
        o_sda_low = 1'b1;
        hold(8);
        o_scl = 1'b0;
        hold(4);
    endtask : bus_start

    task automatic bus_stop();
        o_sda_low = 1'b1;
        hold(4);
        o_scl = 1'b1;
        hold(8);
        o_sda_low = 1'b0;
        hold(8);
    endtask : bus_stop

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(!b[i], s);
        clk_bit(1'b0, ack);
    endtask : send_byte

    task automatic recv_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b0, b[i]);
        clk_bit(!nack, s);
    endtask : recv_byte
endmodule : omm_host_model

// file: test/optical_module_mgmt_iface_tb_top.sv
// Self-checking bench for the management side with a two-wire host model.
`timescale 1ns/100ps
module optical_module_mgmt_iface_tb_top;
    logic        clk, srst, scl, host_low, sda, transmitter_disable_input, rx_det, wp, a;
    logic        o_sda, sda_oe_n, laser_en, signal_lost_flag, tx_fault, present_n, ext_cal, busy;
    logic [15:0] raw [5];
    logic [15:0] corner [5] = '{16'h00FF, 16'h0150, 16'hF001, 16'hE001, 16'h8000};
    logic [7:0]  rbuf [16];
    logic [4:0]  ah;
    logic [31:0] seed;
    int          mismatches, checked;

    // Open-drain line with a pull-up: released means high.
    assign sda = host_low ? 1'b0 : (!sda_oe_n ? o_sda : 1'b1);

    omm_mgmt_top uut (.i_clk(clk), .i_srst(srst), .i_scl_clk(scl), .i_sda(sda),
        .o_sda(o_sda), .o_sda_oe_n(sda_oe_n), .i_transmitter_disable_input(transmitter_disable_input),
        .i_rx_signal_detect(rx_det), .i_id_wp(wp), .o_laser_en(laser_en),
        .o_signal_lost_flag(signal_lost_flag), .o_transmitter_fault_flag(tx_fault),
        .o_present_n(present_n), .o_ext_cal(ext_cal), .o_link_busy(busy),
        .i_temp_raw(raw[0]), .i_vcc_raw(raw[1]), .i_bias_raw(raw[2]),
        .i_txpwr_raw(raw[3]), .i_rxpwr_raw(raw[4]));
    omm_host_model host (.i_sda(sda), .o_scl(scl), .o_sda_low(host_low));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs

    // Kind 0..3: high alarm, low alarm, high warning, low warning.
    function automatic logic [4:0] flags(input int k);
        logic [4:0] f;
        for (int i = 0; i < 5; i++)
            f[i] = k == 0 ? raw[i] > 16'hF000 : k == 1 ? raw[i] < 16'h0100 :
                   k == 2 ? raw[i] > 16'hE000 : raw[i] < 16'h0200;
        return f;
    endfunction : flags

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic conclude();
        if (mismatches == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    task automatic wr(input logic [7:0] dev, adr, d0, d1, input int n);
        logic [7:0] q [3];
        logic       k;
        q = '{adr, d0, d1};
        host.bus_start();
        host.send_byte(dev, k);
        check("address ack", 16'(k), 16'h0000);
        for (int i = 0; i <= n; i++)
        begin
            host.send_byte(q[i], k);
            check("byte ack", 16'(k), 16'h0000);
        end
        host.bus_stop();
    endtask : wr

    task automatic rd(input logic [7:0] dev, adr, input int n);
        logic k;
        host.bus_start();
        host.send_byte(dev, k);
        host.send_byte(adr, k);
        host.bus_start();
        host.send_byte(dev | 8'h01, k);
        check("read address ack", 16'(k), 16'h0000);
        for (int i = 0; i < n; i++)
            host.recv_byte(i == n - 1, rbuf[i]);
        host.bus_stop();
    endtask : rd

    task automatic pins(input logic dis, det);
        @(posedge clk);
        transmitter_disable_input   <= dis;
        rx_det <= det;
        repeat (4) @(posedge clk);
        #1;
        check("laser enable", 16'(laser_en), 16'(!dis));
        check("loss of signal", 16'(signal_lost_flag), 16'(!det));
        check("presence", 16'(present_n), 16'h0000);
    endtask : pins

    // About 100 bytes at 2.2 us each; this limit leaves well over twice that.
    initial
    begin
        #600000;
        mismatches++;
        conclude();
    end

    initial
    begin
        seed = 32'h5A9C;
        srst = 1'b1;
        transmitter_disable_input = 1'b1;
        rx_det = 1'b0;
        wp = 1'b0;
        for (int i = 0; i < 5; i++)
            raw[i] = 16'h0000;
        fork
            host.idle_pulses(4);
        join_none
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (8) @(posedge clk);
        // The link reset only clears on serial clock edges after release.
        host.idle_pulses(3);
        pins(1'b0, 1'b0);
        pins(1'b1, 1'b1);
        for (int i = 0; i < 6; i++)
        begin
            seed = xs(seed);
            pins(seed[0], seed[1]);
        end
        wr(8'hA0, 8'h05, 8'h3C, 8'hC3, 2);
        rd(8'hA0, 8'h05, 2);
        check("id byte", 16'(rbuf[0]), 16'h003C);
        check("id next byte", 16'(rbuf[1]), 16'h00C3);
        wr(8'hA0, 8'hFF, 8'h11, 8'h22, 2);
        rd(8'hA0, 8'hFF, 2);
        check("last byte", 16'(rbuf[0]), 16'h0011);
        check("wrapped byte", 16'(rbuf[1]), 16'h0022);
        @(posedge clk);
        wp <= 1'b1;
        repeat (6) @(posedge clk);
        wr(8'hA0, 8'h05, 8'h99, 8'h00, 1);
        rd(8'hA0, 8'h05, 1);
        check("protected byte", 16'(rbuf[0]), 16'h003C);
        @(posedge clk);
        wp <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            seed = xs(seed);
            host.bus_start();
            check("link busy", 16'(busy), 16'h0001);
            host.send_byte({seed[6:2] == 5'h14 ? ~seed[6:2] : seed[6:2], seed[1:0], 1'b0}, a);
            check("foreign ack", 16'(a), 16'h0001);
            host.bus_stop();
            check("link idle", 16'(busy), 16'h0000);
        end
        pins(1'b1, 1'b0);
        for (int r = 0; r < 3; r++)
        begin
            @(posedge clk);
            for (int i = 0; i < 5; i++)
            begin
                seed = xs(seed);
                raw[i] <= r == 0 ? corner[i] : seed[15:0];
            end
            repeat (10) @(posedge clk);
            ah = flags(0);
            rd(8'hA2, 8'h00, 16);
            for (int i = 0; i < 5; i++)
                check("diag word", {rbuf[2 * i], rbuf[2 * i + 1]}, raw[i]);
            check("high alarms", 16'(rbuf[10]), 16'(ah));
            check("low alarms", 16'(rbuf[11]), 16'(flags(1)));
            check("high warnings", 16'(rbuf[12]), 16'(flags(2)));
            check("low warnings", 16'(rbuf[13]), 16'(flags(3)));
            check("control", 16'(rbuf[14]), 16'({!rx_det, ah[2] | ah[3], transmitter_disable_input, 1'b0}));
            check("beyond map", 16'(rbuf[15]), 16'h0000);
            check("fault pin", 16'(tx_fault), 16'(ah[2] | ah[3]));
        end
        wr(8'hA2, 8'h0E, 8'h01, 8'h00, 1);
        repeat (4) @(posedge clk);
        check("external calibration", 16'(ext_cal), 16'h0001);
        rd(8'hA2, 8'h0E, 1);
        check("control calibration", 16'(rbuf[0][0]), 16'h0001);
        wr(8'hA2, 8'h0E, 8'h00, 8'h00, 1);
        repeat (4) @(posedge clk);
        check("internal calibration", 16'(ext_cal), 16'h0000);
        conclude();
    end
endmodule : optical_module_mgmt_iface_tb_top
